// ### design/spindle_pkg.sv
// shared constants and carrier types for the spindle command logic
package spindle_pkg;
    localparam int SPEED_W     = 16;
    localparam int POS_W       = 12;
    localparam int RATIO_W     = 7;
    localparam int PARAM_W     = 16;
    localparam int CFG_W       = 8;
    localparam int COIL_EN_BIT = 2;
    localparam int COIL_CYC_W  = 8;
    // coil changeover settle time and its cycle count at 25 MHz
    localparam int COIL_TIME_US   = 2;
    localparam int CLK_MHZ        = 25;
    localparam int COIL_CYC       = COIL_TIME_US * CLK_MHZ;
    localparam logic [RATIO_W-1:0] RATIO_FULL = 7'h64;
    localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000;
    localparam logic [POS_W-1:0]   POS_ZERO   = 12'h000;
    localparam logic [POS_W-1:0]   POS_TOL    = 12'h004;

    typedef enum logic [1:0] {DIR_STOP, DIR_FWD, DIR_REV} dir_t;

    // requests from the sequence program
    typedef struct packed {
        logic forward_run_request;
        logic reverse_run_request;
        logic orient_request;
        logic forward_index_request;
        logic reverse_index_request;
        logic torque_select_low;
        logic torque_select_high;
        logic low_coil_request;
    } req_t;

    // configuration values
    typedef struct packed {
        logic [RATIO_W-1:0] torque_ratio_first;
        logic [RATIO_W-1:0] torque_ratio_second;
        logic [RATIO_W-1:0] torque_ratio_third;
        logic [CFG_W-1:0]   coil_change_enable_cfg;
        logic [POS_W-1:0]   orient_shift;
        logic               orient_dir_rev;
        logic [PARAM_W-1:0] normal_param_set_first;
        logic [PARAM_W-1:0] alt_param_set_first;
    } cfg_t;

    // commands to the serially linked drive
    typedef struct packed {
        dir_t               dir;
        logic [SPEED_W-1:0] speed;
        logic               current_on;
        logic               servo_lock;
        logic               position_mode;
        logic [POS_W-1:0]   target;
        logic [RATIO_W-1:0] torque_ratio;
        logic               coil_switch;
        logic [PARAM_W-1:0] param_word;
    } cmd_t;
endpackage

// ### design/spindle_coil_change.sv
// low-speed coil changeover sequencer
`timescale 1ns/1ps
module spindle_coil_change
    import spindle_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic request,
    output logic      coil_switch,
    output logic      coil_active
);
    logic [COIL_CYC_W-1:0] cnt_r;
    logic [COIL_CYC_W-1:0] cnt_nxt;
    logic                  sw_r;
    logic                  act_r;
    logic                  want;

    assign want        = enable & request;
    assign coil_switch = sw_r;
    assign coil_active = act_r;
    // count settles after each change of the coil target
    assign cnt_nxt = (want != sw_r) ? '0
                   : (cnt_r == COIL_CYC_W'(COIL_CYC)) ? cnt_r
                   : cnt_r + 1'b1;

    // switch coils, flag once the settle count is reached
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt_r <= '0;
            sw_r  <= 1'b0;
            act_r <= 1'b0;
        end else begin
            sw_r  <= want;
            cnt_r <= cnt_nxt;
            act_r <= sw_r & want
                   & (cnt_r == COIL_CYC_W'(COIL_CYC));
        end
    end

    coil_flag_a: assert property (@(posedge mclk) disable iff (reset)
        coil_active |-> coil_switch)
        else $error("coil flag without coil switched");
endmodule

// ### design/spindle_control.sv
// spindle run, orient, index and coil command logic
`timescale 1ns/1ps
// Summary of operation
// - reverse request alone runs the motor reverse at commanded speed.
// - dropping the run request decelerates to stop then cuts current.
// - both run requests stop; both must drop before a single restart.
// - after halt, wait servo ready and a low-then-high run request.
// - zero speed keeps motor still; speed changes followed at once.
// - orientation request overrides both run requests.
// - select bits 01, 10, 11 choose first, second, third torque ratio.
// - torque select acts only with the serial drive attached.
// - each fresh index request while orienting makes a new move; code makes none when the index target lies within the position band.
// - early index: finish orientation, then index unless within the position band.
// - index position word latched on index request rising edge.
// - index drop holds stop; mid-move drop still finishes the move.
// - in-position may stay set when target lies within the band.
// - orientation drop releases servo lock; motor coasts.
// - reverse index behaves as forward index in opposite direction.
// - orientation positions at set point, then flags in-position.
// - servo lock held while orientation request stays asserted.
// - encoder stop point is marker plus shift plus multi-point data.
// - enabled coil select switches coils, then flags coil active.
// - coil active selects the alternate parameter set.
module spindle_control
    import spindle_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               reset,
    input  wire spindle_pkg::req_t  req,
    input  wire spindle_pkg::cfg_t  cfg,
    input  wire logic [15:0]        speed_command,
    input  wire logic [11:0]        index_position_word,
    input  wire logic [11:0]        multi_point_data,
    input  wire logic [11:0]        spindle_position,
    input  wire logic               motor_stopped,
    input  wire logic               servo_ready_flag,
    input  wire logic               run_halt,
    input  wire logic               serial_attached,
    output spindle_pkg::cmd_t       cmd,
    output logic                    in_position_flag,
    output logic                    low_coil_active
);
    typedef enum logic [2:0] {
        S_IDLE, S_RUN, S_DECEL, S_BLOCK, S_ORIENT, S_HOLD, S_INDEX
    } state_t;

    state_t             state_r;
    state_t             state_nxt;
    dir_t               dir_r;
    dir_t               dir_nxt;
    logic [POS_W-1:0]   target_r;
    logic [POS_W-1:0]   target_nxt;
    logic [POS_W-1:0]   index_latch_r;
    logic               index_pend_r;
    logic               index_rev_r;
    logic               fwd_idx_d_r;
    logic               rev_idx_d_r;
    logic               run_seen_low_r;
    logic               inpos_r;
    cmd_t               cmd_r;

    // decoded request conditions
    logic fwd_only;
    logic rev_only;
    logic run_conflict;
    logic run_any;
    logic orient;
    logic fwd_idx_rise;
    logic rev_idx_rise;
    logic idx_rise;
    logic [POS_W-1:0] set_point;
    logic [POS_W-1:0] pos_err;
    logic [POS_W-1:0] tgt_err;
    logic at_target;
    logic near_target;
    logic coil_sw;
    logic coil_en;
    logic [RATIO_W-1:0] ratio_sel;
    logic [1:0]         tsel;

    assign fwd_only     = req.forward_run_request & ~req.reverse_run_request;
    assign rev_only     = req.reverse_run_request & ~req.forward_run_request;
    assign run_conflict = req.forward_run_request & req.reverse_run_request;
    assign run_any      = req.forward_run_request | req.reverse_run_request;
    assign orient       = req.orient_request;
    assign fwd_idx_rise = req.forward_index_request & ~fwd_idx_d_r;
    assign rev_idx_rise = req.reverse_index_request & ~rev_idx_d_r;
    assign idx_rise     = fwd_idx_rise | rev_idx_rise;
    // encoder stop point: marker zero plus shift plus multi-point data
    assign set_point = cfg.orient_shift + multi_point_data;
    assign pos_err   = spindle_position - target_r;
    assign tgt_err   = index_latch_r - target_r;
    assign at_target   = (pos_err == POS_ZERO);
    assign near_target = (tgt_err < POS_TOL) | (-tgt_err < POS_TOL);

    // torque ratio decode, only valid on a serially attached drive
    assign tsel = {req.torque_select_high, req.torque_select_low};
    assign ratio_sel = !serial_attached ? RATIO_FULL
                     : (tsel == 2'b01) ? cfg.torque_ratio_first
                     : (tsel == 2'b10) ? cfg.torque_ratio_second
                     : (tsel == 2'b11) ? cfg.torque_ratio_third
                     : RATIO_FULL;
    assign coil_en = cfg.coil_change_enable_cfg[COIL_EN_BIT];

    // next state of run, orient and index sequencing
    always_comb begin
        state_nxt  = state_r;
        dir_nxt    = dir_r;
        target_nxt = target_r;
        if (run_halt) begin
            state_nxt = S_BLOCK;
            dir_nxt   = DIR_STOP;
        end else if (orient) begin
            unique case (state_r)
                S_ORIENT: begin
                    if (at_target & motor_stopped) begin
                        state_nxt = S_HOLD;
                    end
                end
                S_HOLD: begin
                    if (index_pend_r & ~near_target) begin
                        state_nxt  = S_INDEX;
                        target_nxt = index_latch_r;
                        dir_nxt    = index_rev_r ? DIR_REV : DIR_FWD;
                    end else if (index_pend_r) begin
                        target_nxt = index_latch_r;
                    end
                end
                S_INDEX: begin
                    if (at_target & motor_stopped) begin
                        state_nxt = S_HOLD;
                    end
                end
                default: begin
                    state_nxt  = S_ORIENT;
                    target_nxt = set_point;
                    dir_nxt    = cfg.orient_dir_rev ? DIR_REV : DIR_FWD;
                end
            endcase
        end else begin
            unique case (state_r)
                S_IDLE: begin
                    if (fwd_only) begin
                        state_nxt = S_RUN;
                        dir_nxt   = DIR_FWD;
                    end else if (rev_only) begin
                        state_nxt = S_RUN;
                        dir_nxt   = DIR_REV;
                    end else if (run_conflict) begin
                        state_nxt = S_BLOCK;
                    end
                end
                S_RUN: begin
                    if (run_conflict) begin
                        state_nxt = S_BLOCK;
                        dir_nxt   = DIR_STOP;
                    end else if (!run_any) begin
                        state_nxt = S_DECEL;
                    end
                end
                S_DECEL: begin
                    if (motor_stopped) begin
                        state_nxt = S_IDLE;
                        dir_nxt   = DIR_STOP;
                    end
                end
                S_BLOCK: begin
                    if (servo_ready_flag & run_seen_low_r
                        & (fwd_only | rev_only)) begin
                        state_nxt = S_RUN;
                        dir_nxt   = fwd_only ? DIR_FWD : DIR_REV;
                    end
                end
                default: begin
                    state_nxt = S_IDLE;
                    dir_nxt   = DIR_STOP;
                end
            endcase
        end
    end

    // state registers and latched index position
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_r        <= S_IDLE;
            dir_r          <= DIR_STOP;
            target_r       <= POS_ZERO;
            index_latch_r  <= POS_ZERO;
            index_pend_r   <= 1'b0;
            index_rev_r    <= 1'b0;
            fwd_idx_d_r    <= 1'b0;
            rev_idx_d_r    <= 1'b0;
            run_seen_low_r <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            dir_r       <= dir_nxt;
            target_r    <= target_nxt;
            fwd_idx_d_r <= req.forward_index_request;
            rev_idx_d_r <= req.reverse_index_request;
            if (idx_rise & orient) begin
                index_latch_r <= index_position_word;
                index_rev_r   <= rev_idx_rise;
                index_pend_r  <= 1'b1;
            end else if (!orient | (state_r == S_HOLD)) begin
                index_pend_r  <= 1'b0;
            end
            // a fresh low only counts once the drive is ready again
            if (state_nxt != S_BLOCK | !servo_ready_flag) begin
                run_seen_low_r <= 1'b0;
            end else if (!run_any) begin
                run_seen_low_r <= 1'b1;
            end
        end
    end

    // drive command word and flags, all registered
    always_ff @(posedge mclk) begin
        if (reset) begin
            cmd_r   <= '0;
            inpos_r <= 1'b0;
        end else begin
            inpos_r <= (state_nxt == S_HOLD)
                     | ((state_nxt == S_INDEX) & inpos_r & near_target);
            cmd_r.dir           <= dir_nxt;
            cmd_r.speed         <= (state_nxt == S_RUN)
                                 ? speed_command : SPEED_ZERO;
            cmd_r.current_on    <= (state_nxt != S_IDLE)
                                 & (state_nxt != S_BLOCK);
            cmd_r.servo_lock    <= orient & (state_nxt == S_HOLD
                                 | state_nxt == S_INDEX);
            cmd_r.position_mode <= orient;
            cmd_r.target        <= target_nxt;
            cmd_r.torque_ratio  <= ratio_sel;
            cmd_r.coil_switch   <= coil_sw;
            cmd_r.param_word    <= low_coil_active
                                 ? cfg.alt_param_set_first
                                 : cfg.normal_param_set_first;
        end
    end

    assign cmd              = cmd_r;
    assign in_position_flag = inpos_r;

    spindle_coil_change u_coil (
        .mclk        (mclk),
        .reset       (reset),
        .enable      (coil_en),
        .request     (req.low_coil_request),
        .coil_switch (coil_sw),
        .coil_active (low_coil_active)
    );

    rev_run_a: assert property (@(posedge mclk) disable iff (reset)
        (state_r == S_IDLE) && rev_only && !orient && !run_halt
        |=> cmd.dir == DIR_REV && cmd.speed == $past(speed_command))
        else $error("reverse run not commanded");
    conflict_stop_a: assert property (@(posedge mclk) disable iff (reset)
        run_conflict && !orient |=> cmd.speed == SPEED_ZERO)
        else $error("conflicting run requests not stopped");
    halt_block_a: assert property (@(posedge mclk) disable iff (reset)
        run_halt && !orient |=> !cmd.current_on ##1 state_r != S_RUN
        || !run_halt)
        else $error("run resumed during halt");
    orient_prio_a: assert property (@(posedge mclk) disable iff (reset)
        orient && !run_halt |=> cmd.speed == SPEED_ZERO)
        else $error("run speed during orientation");
    torque_sel_a: assert property (@(posedge mclk) disable iff (reset)
        serial_attached && tsel == 2'b10
        |=> cmd.torque_ratio == $past(cfg.torque_ratio_second))
        else $error("wrong torque ratio selected");
    torque_off_a: assert property (@(posedge mclk) disable iff (reset)
        !serial_attached |=> cmd.torque_ratio == RATIO_FULL)
        else $error("torque select acted without link");
    latch_hold_a: assert property (@(posedge mclk) disable iff (reset)
        !idx_rise |=> $stable(index_latch_r))
        else $error("index latch changed without edge");
    lock_drop_a: assert property (@(posedge mclk) disable iff (reset)
        !orient |=> !cmd.servo_lock && !in_position_flag)
        else $error("servo lock kept after orient drop");
    param_set_a: assert property (@(posedge mclk) disable iff (reset)
        low_coil_active |=> cmd.param_word
        == $past(cfg.alt_param_set_first))
        else $error("alternate parameters not used");

    // halt gating and index start checks
    ready_gate_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == S_BLOCK && !servo_ready_flag && !orient
        |=> !cmd.current_on)
        else $error("restart before servo ready");
    idx_move_a: assert property (@(posedge mclk) disable iff (reset)
        state_r == S_HOLD && orient && !run_halt && index_pend_r
        && !near_target |=> cmd.target == $past(index_latch_r)
        && cmd.dir == ($past(index_rev_r) ? DIR_REV : DIR_FWD))
        else $error("index move not started");
endmodule

// ### verification/spindle_drive_model.sv
// behavioural model of the serially linked spindle drive
`timescale 1ns/1ps
module spindle_drive_model
    import spindle_pkg::*;
#(
    parameter int READY_DLY = 10
)
(
    input  wire logic              mclk,
    input  wire logic              reset,
    input  wire spindle_pkg::cmd_t cmd,
    input  wire logic              halt,
    output logic [11:0]            spindle_position,
    output logic                   motor_stopped,
    output logic                   servo_ready_flag
);
    logic [15:0] speed_r;
    logic [7:0]  ready_cnt_r;
    logic        coasting;

    // no drive command: the spindle slows down step by step
    assign coasting = (cmd.dir == DIR_STOP) || !cmd.current_on;

    // spin rate follows the command, ramps down when released
    always_ff @(posedge mclk) begin
        if (reset) begin
            speed_r <= 16'h0000;
        end else if (coasting) begin
            speed_r <= (speed_r > 16'h0100) ? speed_r - 16'h0100 : 16'h0000;
        end else begin
            speed_r <= cmd.speed;
        end
    end

    // shaft angle: one count a cycle while turning or positioning
    always_ff @(posedge mclk) begin
        if (reset) begin
            spindle_position <= 12'h000;
        end else if (cmd.position_mode) begin
            if (spindle_position != cmd.target) begin
                spindle_position <= (cmd.dir == DIR_REV) ?
                    spindle_position - 12'h001 : spindle_position + 12'h001;
            end
        end else if (speed_r != 16'h0000) begin
            spindle_position <= spindle_position + 12'h001;
        end
    end

    assign motor_stopped = cmd.position_mode ?
        (spindle_position == cmd.target) : (speed_r == 16'h0000);

    // ready drops on a halt and returns after a settle delay
    always_ff @(posedge mclk) begin
        if (reset || halt) begin
            ready_cnt_r <= 8'(READY_DLY);
        end else if (ready_cnt_r != 8'h00) begin
            ready_cnt_r <= ready_cnt_r - 8'h01;
        end
    end
    assign servo_ready_flag = (ready_cnt_r == 8'h00);
endmodule

// ### verification/tb.sv
// self-checking bench for the spindle command logic
`timescale 1ns/1ps
module tb;
    import spindle_pkg::*;
    logic              mclk;
    logic              reset;
    req_t              req;
    cfg_t              cfg;
    logic [15:0]       speed_command;
    logic [11:0]       index_position_word;
    logic [11:0]       multi_point_data;
    logic [11:0]       spindle_position;
    logic              motor_stopped;
    logic              servo_ready_flag;
    logic              run_halt;
    logic              serial_attached;
    cmd_t              cmd;
    logic              in_position_flag;
    logic              low_coil_active;
    int                err_count;
    int                num_checks;
    int                seed;
    int                cyc_count;

    spindle_control i_spindle_control (.mclk(mclk), .reset(reset),
        .req(req), .cfg(cfg), .speed_command(speed_command),
        .index_position_word(index_position_word),
        .multi_point_data(multi_point_data),
        .spindle_position(spindle_position), .motor_stopped(motor_stopped),
        .servo_ready_flag(servo_ready_flag), .run_halt(run_halt),
        .serial_attached(serial_attached), .cmd(cmd),
        .in_position_flag(in_position_flag),
        .low_coil_active(low_coil_active));

    spindle_drive_model i_spindle_drive_model (.mclk(mclk), .reset(reset),
        .cmd(cmd), .halt(run_halt), .spindle_position(spindle_position),
        .motor_stopped(motor_stopped), .servo_ready_flag(servo_ready_flag));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge mclk) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 40000) begin
            err_count++;
            $display("[FAIL] run time expected done seen hung");
            close_out();
        end
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [15:0] exp,
                            input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // wait n edges, then sample once outputs have settled
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wait_pos(input logic [11:0] tgt);
        for (int n = 0; n < 6000; n++) begin
            if (in_position_flag === 1'b1 && cmd.target === tgt) break;
            settle(1);
        end
        chk_bit("in_position", 1'b1, in_position_flag);
        chk_word("target", 16'(tgt), 16'(cmd.target));
    endtask

    // limit ratio expected for {attached, high, low}
    function automatic logic [6:0] exp_ratio(input logic [2:0] s);
        if (!s[2] || s[1:0] == 2'b00) return RATIO_FULL;
        case (s[1:0])
            2'b01: return cfg.torque_ratio_first;
            2'b10: return cfg.torque_ratio_second;
            default: return cfg.torque_ratio_third;
        endcase
    endfunction

    initial begin
        logic [15:0] sp;
        logic [11:0] home;
        logic [11:0] w;
        seed = 38;
        err_count = 0;
        num_checks = 0;
        cyc_count = 0;
        reset = 1'b1;
        req = '0;
        cfg = '0;
        cfg.torque_ratio_first = 7'h0a;
        cfg.torque_ratio_second = 7'h14;
        cfg.torque_ratio_third = 7'h1e;
        cfg.orient_shift = 12'($random(seed));
        cfg.orient_dir_rev = 1'b1;
        cfg.normal_param_set_first = 16'($random(seed));
        cfg.alt_param_set_first = ~cfg.normal_param_set_first;
        speed_command = 16'h0000;
        index_position_word = 12'h000;
        multi_point_data = 12'($random(seed));
        run_halt = 1'b0;
        serial_attached = 1'b1;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        settle(1);
        chk_word("cmd speed", 16'h0000, cmd.speed);
        chk_bit("in_position", 1'b0, in_position_flag);
        chk_bit("coil active", 1'b0, low_coil_active);
        // reverse run, speed zero then changed
        sp = 16'($random(seed)) | 16'h1000;
        settle(12);
        @(posedge mclk);
        speed_command <= sp;
        req.reverse_run_request <= 1'b1;
        settle(2);
        chk_word("dir", 16'(DIR_REV), 16'(cmd.dir));
        chk_word("speed", sp, cmd.speed);
        chk_bit("current", 1'b1, cmd.current_on);
        @(posedge mclk);
        speed_command <= 16'h0000;
        settle(2);
        chk_word("speed", 16'h0000, cmd.speed);
        @(posedge mclk);
        speed_command <= sp;
        settle(2);
        chk_word("speed", sp, cmd.speed);
        @(posedge mclk);
        req.reverse_run_request <= 1'b0;
        settle(2);
        chk_word("dir", 16'(DIR_REV), 16'(cmd.dir));
        chk_bit("current", 1'b1, cmd.current_on);
        for (int n = 0; n < 400 && motor_stopped !== 1'b1; n++) settle(1);
        settle(2);
        chk_bit("current", 1'b0, cmd.current_on);
        $display("test run done");
        // both runs, then a single run only after both dropped
        @(posedge mclk);
        req.forward_run_request <= 1'b1;
        req.reverse_run_request <= 1'b1;
        settle(2);
        chk_word("dir", 16'(DIR_STOP), 16'(cmd.dir));
        @(posedge mclk);
        req.reverse_run_request <= 1'b0;
        settle(2);
        chk_word("dir", 16'(DIR_STOP), 16'(cmd.dir));
        @(posedge mclk);
        req.forward_run_request <= 1'b0;
        @(posedge mclk);
        req.forward_run_request <= 1'b1;
        settle(2);
        chk_word("dir", 16'(DIR_FWD), 16'(cmd.dir));
        // halt: restart needs ready plus a fresh run edge
        @(posedge mclk);
        run_halt <= 1'b1;
        settle(2);
        chk_word("dir", 16'(DIR_STOP), 16'(cmd.dir));
        @(posedge mclk);
        run_halt <= 1'b0;
        req.forward_run_request <= 1'b0;
        @(posedge mclk);
        req.forward_run_request <= 1'b1;
        settle(16);
        chk_word("dir", 16'(DIR_STOP), 16'(cmd.dir));
        @(posedge mclk);
        req.forward_run_request <= 1'b0;
        @(posedge mclk);
        req.forward_run_request <= 1'b1;
        settle(2);
        chk_word("dir", 16'(DIR_FWD), 16'(cmd.dir));
        $display("test arbitration done");
        // orientation while the forward run is still requested
        home = cfg.orient_shift + multi_point_data;
        @(posedge mclk);
        req.orient_request <= 1'b1;
        settle(2);
        chk_bit("position mode", 1'b1, cmd.position_mode);
        chk_word("dir", 16'(DIR_REV), 16'(cmd.dir));
        chk_word("target", 16'(home), 16'(cmd.target));
        wait_pos(home);
        chk_bit("servo lock", 1'b1, cmd.servo_lock);
        @(posedge mclk);
        req.forward_run_request <= 1'b0;
        // every torque select code, attached and not
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            {serial_attached, req.torque_select_high,
             req.torque_select_low} <= 3'(i);
            settle(2);
            chk_word("ratio", 16'(exp_ratio(3'(i))),
                     16'(cmd.torque_ratio));
        end
        $display("test orient and torque done");
        // forward then reverse index, word changed and request dropped
        for (int k = 0; k < 2; k++) begin
            w = cmd.target ^ 12'h800;
            @(posedge mclk);
            index_position_word <= w;
            req.forward_index_request <= (k == 0);
            req.reverse_index_request <= (k == 1);
            repeat (2) @(posedge mclk);
            index_position_word <= ~w;
            req.forward_index_request <= 1'b0;
            req.reverse_index_request <= 1'b0;
            for (int n = 0; n < 20 && cmd.target !== w; n++) settle(1);
            chk_word("dir", 16'(k ? DIR_REV : DIR_FWD),
                     16'(cmd.dir));
            wait_pos(w);
            settle(5);
            chk_word("hold", 16'(w), 16'(cmd.target));
            chk_bit("servo lock", 1'b1, cmd.servo_lock);
        end
        // index to the present stop point makes no move
        @(posedge mclk);
        index_position_word <= cmd.target;
        req.forward_index_request <= 1'b1;
        settle(4);
        chk_bit("in_position", 1'b1, in_position_flag);
        chk_word("target", 16'(w), 16'(cmd.target));
        // orientation drop releases the lock, later index ignored
        @(posedge mclk);
        req.forward_index_request <= 1'b0;
        req.orient_request <= 1'b0;
        settle(2);
        chk_bit("servo lock", 1'b0, cmd.servo_lock);
        @(posedge mclk);
        req.forward_index_request <= 1'b1;
        settle(3);
        chk_bit("position mode", 1'b0, cmd.position_mode);
        // index arriving before orientation completes
        w = home ^ 12'h400;
        @(posedge mclk);
        req.forward_index_request <= 1'b0;
        req.orient_request <= 1'b1;
        @(posedge mclk);
        index_position_word <= w;
        req.forward_index_request <= 1'b1;
        wait_pos(w);
        @(posedge mclk);
        req.orient_request <= 1'b0;
        req.forward_index_request <= 1'b0;
        $display("test index done");
        // coil select, first disabled, then enabled
        @(posedge mclk);
        req.low_coil_request <= 1'b1;
        settle(COIL_CYC + 10);
        chk_bit("coil active", 1'b0, low_coil_active);
        chk_word("param", cfg.normal_param_set_first,
                 cmd.param_word);
        @(posedge mclk);
        cfg.coil_change_enable_cfg <= 8'h04;
        settle(COIL_CYC / 2);
        chk_bit("coil switch", 1'b1, cmd.coil_switch);
        chk_bit("coil active", 1'b0, low_coil_active);
        settle(COIL_CYC);
        chk_bit("coil active", 1'b1, low_coil_active);
        chk_word("param", cfg.alt_param_set_first,
                 cmd.param_word);
        $display("test coil done");
        close_out();
    end
endmodule
